//--- rtl/ppg_top.sv
/*
 * Test pattern generator: PRBS and square-wave beats onto a streaming
 * source, controlled over an AXI4-Lite slave.
 * Assumes one clock, a synchronous active-low reset, and a sink that
 * may withhold ready at any time.
 */
`timescale 1ns/10ps
`default_nettype none
module ppg_top #(
	parameter int DATA_W = 32,
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [4:0] s_awaddr,
	// AXI4-Lite write data
	input wire logic s_wvalid,
	output logic s_wready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	// AXI4-Lite write response
	output logic s_bvalid,
	input wire logic s_bready,
	output logic [1:0] s_bresp,
	// AXI4-Lite read address
	input wire logic s_arvalid,
	output logic s_arready,
	input wire logic [4:0] s_araddr,
	// AXI4-Lite read data
	output logic s_rvalid,
	input wire logic s_rready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	// Pattern stream
	output logic st_valid,
	input wire logic st_ready,
	output logic [DATA_W-1:0] st_data
);
	localparam int SYM_W = DATA_W / 4;
	localparam int HI_W = DATA_W - 32;
	// Idle word differs per build, not a plain slice of the wide one
	localparam logic [DATA_W-1:0] IDLE_BEAT = (DATA_W == 32)
		? DATA_W'(ppg_pkg::IDLE_NARROW) : DATA_W'(ppg_pkg::IDLE_WORD);

	typedef enum logic [1:0] {
		GEN_IDLE = 2'b00,
		GEN_PRE = 2'b01,
		GEN_RUN = 2'b10
	} ppg_gen_t;

	typedef struct packed {
		ppg_gen_t gen;
		logic [30:0] lfsr;
		logic [7:0] pre_left;
		logic enable;
		logic [ppg_pkg::PAT_W-1:0] pattern;
		logic inject;
		logic pre_en;
		logic [7:0] pre_cnt;
		logic [31:0] pre_lo;
		logic [7:0] pre_hi;
		logic aw_full;
		logic [2:0] aw_idx;
		logic aw_bad;
		logic w_full;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ppg_state_t;

	ppg_state_t st;
	ppg_state_t next_st;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [DATA_W-1:0] fifo_out_data;
	logic push;
	logic [DATA_W-1:0] beat;
	logic [DATA_W+30:0] prbs;
	logic [31:0] rd_word;
	logic rd_bad;
	logic rd_bad_addr;
	logic [2:0] rd_idx;

	// =========================================================
	// Functions

	// Steps the LFSR one beat; bits come out MSB first
	function automatic logic [DATA_W+30:0] prbs_beat(input logic [30:0] s_in,
		input logic [ppg_pkg::PAT_W-1:0] sel);
		logic [30:0] s;
		logic [DATA_W-1:0] d;
		logic fb;
		s = s_in;
		d = '0;
		fb = 1'b0;
		for (int i = DATA_W - 1; i >= 0; i--)
		begin
			unique case (sel)
				ppg_pkg::PAT_PRBS7: fb = s[6] ^ s[5];
				ppg_pkg::PAT_PRBS15: fb = s[14] ^ s[13];
				ppg_pkg::PAT_PRBS23: fb = s[22] ^ s[17];
				default: fb = s[30] ^ s[27];
			endcase
			d[i] = fb;
			s = {s[29:0], fb};
		end
		return {s, d};
	endfunction

	// Square wave: alternating or half-on per symbol
	function automatic logic [DATA_W-1:0] square_beat(input logic low);
		logic [DATA_W-1:0] d;
		d = '0;
		for (int i = 0; i < DATA_W; i++)
		begin
			if (low)
				d[i] = ((i % SYM_W) >= (SYM_W / 2));
			else
				d[i] = ((i % SYM_W) % 2 == 1);
		end
		return d;
	endfunction

	// Register index from a byte address, flags misaligned or unmapped
	function automatic logic [3:0] decode(input logic [4:0] addr);
		logic [2:0] idx;
		logic bad;
		idx = addr[4:2];
		bad = (addr[1:0] != 2'b00) || (idx > ppg_pkg::IDX_STATUS);
		return {bad, idx};
	endfunction

	// =========================================================
	// Output queue; stalls the generator when the sink holds off
	ppg_fifo #(
		.W(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_valid(st.gen != GEN_IDLE),
		.in_ready(fifo_in_ready),
		.in_data(beat),
		.out_valid(fifo_out_valid),
		.out_ready(st_ready),
		.out_data(fifo_out_data)
	);

	// Stream outputs; the idle word shows whenever nothing is queued
	assign st_valid = fifo_out_valid;
	assign st_data = fifo_out_valid ? fifo_out_data : IDLE_BEAT;
	assign push = (st.gen != GEN_IDLE) && fifo_in_ready;

	// Bus outputs
	assign s_awready = !st.aw_full;
	assign s_wready = !st.w_full;
	assign s_bvalid = st.bvalid;
	assign s_bresp = st.bresp;
	assign s_arready = !st.rvalid;
	assign s_rvalid = st.rvalid;
	assign s_rdata = st.rdata;
	assign s_rresp = st.rresp;
	// Read address split into word index and a refusal flag
	assign {rd_bad_addr, rd_idx} = decode(s_araddr);

	// =========================================================
	// Beat formation
	always_comb
	begin
		prbs = prbs_beat(st.lfsr, st.pattern);
		if (st.gen == GEN_PRE)
			beat = DATA_W'({st.pre_hi, st.pre_lo});
		else if (st.pattern == ppg_pkg::PAT_HIGH)
			beat = square_beat(1'b0);
		else if (st.pattern == ppg_pkg::PAT_LOW)
			beat = square_beat(1'b1);
		else
			beat = prbs[DATA_W-1:0];
		if (st.inject)
			beat[0] = ~beat[0];
	end

	// Read mux; reserved bits read zero
	always_comb
	begin
		{rd_bad, rd_word} = {1'b0, 32'h0000_0000};
		unique case (rd_idx)
			ppg_pkg::IDX_ENABLE: rd_word[ppg_pkg::EN_BIT] = st.enable;
			ppg_pkg::IDX_PATTERN: rd_word[ppg_pkg::PAT_W-1:0] = st.pattern;
			ppg_pkg::IDX_INJECT: rd_word[ppg_pkg::INJ_BIT] = st.inject;
			ppg_pkg::IDX_PRE_CTRL:
			begin
				rd_word[ppg_pkg::PRE_EN_BIT] = st.pre_en;
				rd_word[ppg_pkg::PRE_CNT_LSB +: 8] = st.pre_cnt;
			end
			ppg_pkg::IDX_PRE_LO: rd_word = st.pre_lo;
			ppg_pkg::IDX_PRE_HI: rd_word[7:0] = st.pre_hi;
			ppg_pkg::IDX_STATUS: rd_word[3:0] = {st.inject, fifo_out_valid,
				st.gen == GEN_PRE, st.gen != GEN_IDLE};
			default: rd_bad = 1'b1;
		endcase
		if (rd_bad_addr)
		begin
			rd_bad = 1'b1;
			rd_word = 32'h0000_0000;
		end
	end

	// =========================================================
	// Next state: generator first, then bus writes so a set wins
	always_comb
	begin
		next_st = st;

		// Generator sequencing
		unique case (st.gen)
			GEN_IDLE:
			begin
				if (st.enable)
				begin
					next_st.lfsr = ppg_pkg::PRBS_SEED;
					next_st.pre_left = st.pre_cnt;
					next_st.gen = (st.pre_en && st.pre_cnt != 8'h00) ? GEN_PRE : GEN_RUN;
				end
			end
			GEN_PRE:
			begin
				if (push)
				begin
					next_st.pre_left = st.pre_left - 8'h01;
					if (st.pre_left == 8'h01)
						next_st.gen = GEN_RUN;
				end
			end
			GEN_RUN:
			begin
				if (push)
					next_st.lfsr = prbs[DATA_W+30:DATA_W];
			end
			default: next_st.gen = GEN_IDLE;
		endcase
		if (!st.enable)
			next_st.gen = GEN_IDLE;
		if (push)
			next_st.inject = 1'b0;

		// Write address and data may arrive in either order
		if (s_awvalid && !st.aw_full)
		begin
			next_st.aw_full = 1'b1;
			{next_st.aw_bad, next_st.aw_idx} = decode(s_awaddr);
		end
		if (s_wvalid && !st.w_full)
		begin
			next_st.w_full = 1'b1;
			next_st.wdata = s_wdata;
			next_st.wstrb = s_wstrb;
		end

		// Commit a write once both halves are held
		if (st.aw_full && st.w_full && !st.bvalid)
		begin
			next_st.aw_full = 1'b0;
			next_st.w_full = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = st.aw_bad ? ppg_pkg::RESP_SLVERR : ppg_pkg::RESP_OKAY;
			if (!st.aw_bad)
			begin
				unique case (st.aw_idx)
					ppg_pkg::IDX_ENABLE:
						if (st.wstrb[0])
							next_st.enable = st.wdata[ppg_pkg::EN_BIT];
					ppg_pkg::IDX_PATTERN:
						if (st.wstrb[0])
						begin
							next_st.pattern = st.wdata[ppg_pkg::PAT_W-1:0];
							next_st.lfsr = ppg_pkg::PRBS_SEED;
						end
					ppg_pkg::IDX_INJECT:
						if (st.wstrb[0] && st.wdata[ppg_pkg::INJ_BIT])
							next_st.inject = 1'b1;
					ppg_pkg::IDX_PRE_CTRL:
						if (!st.enable)
						begin
							if (st.wstrb[0])
								next_st.pre_en = st.wdata[ppg_pkg::PRE_EN_BIT];
							if (st.wstrb[1])
								next_st.pre_cnt = st.wdata[ppg_pkg::PRE_CNT_LSB +: 8];
						end
					ppg_pkg::IDX_PRE_LO:
						for (int b = 0; b < 4; b++)
							if (st.wstrb[b])
								next_st.pre_lo[b*8 +: 8] = st.wdata[b*8 +: 8];
					ppg_pkg::IDX_PRE_HI:
						if (st.wstrb[0] && HI_W > 0)
							next_st.pre_hi = st.wdata[7:0];
					default: next_st.bresp = ppg_pkg::RESP_OKAY;
				endcase
			end
		end
		if (st.bvalid && s_bready)
			next_st.bvalid = 1'b0;

		// Reads answer one cycle after the address is taken
		if (s_arvalid && !st.rvalid)
		begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_word;
			next_st.rresp = rd_bad ? ppg_pkg::RESP_SLVERR : ppg_pkg::RESP_OKAY;
		end
		else if (st.rvalid && s_rready)
			next_st.rvalid = 1'b0;
	end

	// =========================================================
	// State register; width is fixed by parameter only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= '0;
			st.gen <= GEN_IDLE;
			st.pattern <= ppg_pkg::PAT_RESET;
			st.pre_cnt <= ppg_pkg::PRE_CNT_RESET;
			st.lfsr <= ppg_pkg::PRBS_SEED;
		end
		else
			st <= next_st;
	end
endmodule // ppg_top
`default_nettype wire

//--- rtl/ppg_pkg.sv
/*
 * Shared constants for the pattern generator: register indices,
 * field positions, reset values and pattern codes.
 * Assumes a 32-bit AXI4-Lite register bus, one word per register.
 */
package ppg_pkg;
	// =========================================================
	// Register indices (byte address is four times the index)
	localparam logic [2:0] IDX_ENABLE = 3'h0;
	localparam logic [2:0] IDX_PATTERN = 3'h1;
	localparam logic [2:0] IDX_INJECT = 3'h2;
	localparam logic [2:0] IDX_PRE_CTRL = 3'h3;
	localparam logic [2:0] IDX_PRE_LO = 3'h4;
	localparam logic [2:0] IDX_PRE_HI = 3'h5;
	localparam logic [2:0] IDX_STATUS = 3'h6;
	localparam int ADDR_SHIFT = 2;

	// =========================================================
	// Field positions
	localparam int EN_BIT = 0;
	localparam int INJ_BIT = 0;
	localparam int PRE_EN_BIT = 0;
	localparam int PRE_CNT_LSB = 8;
	localparam int PAT_W = 3;

	// =========================================================
	// Pattern codes
	localparam logic [2:0] PAT_PRBS7 = 3'h0;
	localparam logic [2:0] PAT_PRBS15 = 3'h1;
	localparam logic [2:0] PAT_PRBS23 = 3'h2;
	localparam logic [2:0] PAT_PRBS31 = 3'h3;
	localparam logic [2:0] PAT_HIGH = 3'h4;
	localparam logic [2:0] PAT_LOW = 3'h5;

	// =========================================================
	// Reset values and seed
	localparam logic [2:0] PAT_RESET = 3'h0;
	localparam logic [7:0] PRE_CNT_RESET = 8'h00;
	localparam logic [30:0] PRBS_SEED = 31'h7fff_ffff;
	// Idle words: narrow build shows 5555, wide build 55555
	localparam logic [31:0] IDLE_NARROW = 32'h0000_5555;
	localparam logic [39:0] IDLE_WORD = 40'h00_0005_5555;

	// =========================================================
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- rtl/ppg_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
module ppg_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} ppg_fifo_t;

	ppg_fifo_t st;
	ppg_fifo_t next_st;
	logic push;
	logic pop;

	// Honest flags straight from the occupancy count
	assign in_ready = (st.cnt != (AW+1)'(DEPTH));
	assign out_valid = (st.cnt != '0);
	assign out_data = st.mem[st.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and count update
	always_comb
	begin
		next_st = st;
		if (push)
		begin
			next_st.mem[st.wp] = in_data;
			next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + 1'b1;
		end
		if (pop)
			next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + 1'b1;
		if (push && !pop)
			next_st.cnt = st.cnt + 1'b1;
		else if (pop && !push)
			next_st.cnt = st.cnt - 1'b1;
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end
endmodule // ppg_fifo
`default_nettype wire

//--- verif/ppg_top_assertions.sv
/* Port checker for the pattern generator, bound onto ppg_top.
   Assumes one clock, synchronous active-low reset, 32-bit bus. */
`timescale 1ns/10ps
`default_nettype none
module ppg_top_assertions #(
	parameter int DATA_W = 32
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_awvalid,
	input wire logic s_awready,
	input wire logic s_wvalid,
	input wire logic s_wready,
	input wire logic s_bvalid,
	input wire logic s_bready,
	input wire logic [1:0] s_bresp,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic [4:0] s_araddr,
	input wire logic s_rvalid,
	input wire logic s_rready,
	input wire logic [31:0] s_rdata,
	input wire logic [1:0] s_rresp,
	// Stream
	input wire logic st_valid,
	input wire logic st_ready,
	input wire logic [DATA_W-1:0] st_data
);
	// =========================================================
	// Stream and bus relations
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_HOLD: assert property (st_valid && !st_ready |=> st_valid && $stable(st_data))
		else $error("stream beat moved while stalled");
	AST_IDLE: assert property (!st_valid |-> st_data == DATA_W'(DATA_W == 32 ?
		40'h00_0000_5555 : 40'h00_0005_5555)) else $error("idle word wrong");
	AST_BHOLD: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
		else $error("write answer dropped early");
	AST_RHOLD: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
		else $error("read answer dropped early");
	AST_RVAL: assert property (s_arvalid && s_arready |-> ##[1:2] s_rvalid)
		else $error("read answer missing");
	AST_ARRDY: assert property (s_rvalid |-> !s_arready)
		else $error("read taken while answer pending");
	AST_BADRD: assert property (s_arvalid && s_arready && s_araddr[1:0] != 2'h0
		|-> ##[1:2] s_rvalid && s_rresp == ppg_pkg::RESP_SLVERR && s_rdata == 32'h0000_0000)
		else $error("misaligned read not refused");
	AST_BVAL: assert property (s_awvalid && s_awready && s_wvalid && s_wready
		|-> ##[1:2] s_bvalid) else $error("write answer missing");
endmodule // ppg_top_assertions
bind ppg_top ppg_top_assertions #(.DATA_W(DATA_W)) u_ppg_top_assertions (.*);
`default_nettype wire

//--- verif/ppg_sink.sv
/* Stream sink standing in for the downstream checker.
   Assumes the bench reads the captured beats from got. */
`timescale 1ns/10ps
`default_nettype none
module ppg_sink (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pace: high makes ready random
	input wire logic slow,
	// Stream
	input wire logic st_valid,
	input wire logic [31:0] st_data,
	output var logic st_ready
);
	logic [31:0] got[$];
	int sd;
	initial
	begin
		sd = 32'h8831;
	end
	// Capture accepted beats; with slow high, stalls often to fill the FIFO
	always @(posedge aclk)
	begin
		if (st_valid && st_ready)
			got.push_back(st_data);
		st_ready <= aresetn && (!slow || ($random(sd) & 3) == 0);
	end
endmodule // ppg_sink
`default_nettype wire

//--- verif/ppg_top_tb.sv
/* Self-checking bench for the pattern generator, 32-bit build.
   Assumes the sink model in ppg_sink.sv and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module ppg_top_tb;
	logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready, st_valid, st_ready, slow;
	logic [4:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, st_data, ch, rv, lf;
	logic [3:0] s_wstrb;
	logic [1:0] s_bresp, s_rresp, rr;
	int n_fail, n_checks, seed, ord, tap;
	ppg_top #(.DATA_W(32), .FIFO_DEPTH(4)) u_ppg_top (.*);
	ppg_sink u_ppg_sink (.aclk(aclk), .aresetn(aresetn), .slow(slow), .st_valid(st_valid),
		.st_data(st_data), .st_ready(st_ready));
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// =========================================================
	// Compare, verdict and bus tasks
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task results;
		if (n_fail == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Ready sampled at the falling edge, so it is the value the edge sees
	task wr(input logic [4:0] a, input logic [31:0] d);
		bit av, wv;
		@(posedge aclk);
		{s_awvalid, s_wvalid, s_bready, s_awaddr, s_wdata} <= {3'b111, a, d};
		av = 1;
		wv = 1;
		while (av || wv)
		begin
			@(negedge aclk);
			if (s_awready) av = 0;
			if (s_wready) wv = 0;
			@(posedge aclk);
			s_awvalid <= av;
			s_wvalid <= wv;
		end
		while (!s_bvalid) @(negedge aclk);
		chk("bresp", 32'h0000_0000, {30'h0, s_bresp});
		@(posedge aclk);
		s_bready <= 1'b0;
	endtask
	task rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		{s_arvalid, s_rready, s_araddr} <= {2'b11, a};
		do @(negedge aclk); while (!s_arready);
		@(posedge aclk);
		s_arvalid <= 1'b0;
		do @(negedge aclk); while (!s_rvalid);
		d = s_rdata;
		r = s_rresp;
		@(posedge aclk);
		s_rready <= 1'b0;
	endtask
	// =========================================================
	// Reference beats: one LFSR step per bit, first bit at the MSB
	task beat(input int p, output logic [31:0] b);
		logic nb;
		if (p == 4) b = 32'hAAAA_AAAA;
		else if (p == 5) b = 32'hF0F0_F0F0;
		else for (int i = 31; i >= 0; i--)
		begin
			nb = lf[ord-1] ^ lf[tap-1];
			lf = {lf[30:0], nb};
			b[i] = nb;
		end
	endtask
	task run(input int p, input int n, input int pre, input bit inj);
		logic [31:0] e;
		ord = p == 0 ? 7 : p == 1 ? 15 : p == 2 ? 23 : 31;
		tap = p == 0 ? 6 : p == 1 ? 14 : p == 2 ? 18 : 28;
		lf = 32'h7FFF_FFFF;
		slow <= p[0];
		wr(5'h04, 32'(p));
		wr(5'h0C, {16'h0000, 8'(pre), 8'h01});
		if (inj) wr(5'h08, 32'h0000_0001);
		wr(5'h00, 32'h0000_0001);
		while (u_ppg_sink.got.size() < n + pre) @(posedge aclk);
		rd(5'h18, rv, rr);
		chk("status", 32'h0000_0001, rv & 32'h0000_000B);
		wr(5'h00, 32'h0000_0000);
		// Queued beats still drain after the disable; wait them out
		repeat (8) @(posedge aclk);
		while (st_valid) @(posedge aclk);
		foreach (u_ppg_sink.got[k])
		begin
			if (k < pre) e = ch;
			else beat(p, e);
			if (k == 0 && inj) e[0] = ~e[0];
			chk("beat", e, u_ppg_sink.got[k]);
		end
		u_ppg_sink.got.delete();
		rd(5'h08, rv, rr);
		chk("inject", 32'h0000_0000, rv);
	endtask
	// =========================================================
	// Main sequence
	initial
	begin
		{aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, slow} = 7'h00;
		{s_awaddr, s_araddr, s_wdata, s_wstrb} = {10'h000, 32'h0000_0000, 4'hF};
		seed = 32'h8831;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk("idle", 32'h0000_5555, st_data);
		for (int a = 0; a < 9; a++)
		begin
			rd(a == 8 ? 5'h02 : 5'(a * 4), rv, rr);
			chk("reg", 32'h0000_0000, rv);
			chk("resp", {30'h0, a < 7 ? ppg_pkg::RESP_OKAY : ppg_pkg::RESP_SLVERR}, {30'h0, rr});
		end
		ch = $random(seed);
		wr(5'h10, ch);
		for (int p = 0; p < 6; p++) run(p, 24, p == 5 ? 255 : 0, p == 4);
		results();
	end
	// Watchdog well past the expected few thousand cycles
	initial
	begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		results();
	end
endmodule // ppg_top_tb
`default_nettype wire
